/* src/ssac_pkg.sv */
// package: address map, handler addresses, boot states and carried structs
package ssac_pkg;

    // section bases of the flat 32-bit space
    localparam logic [31:0] RAM_BASE = 32'h0000_0000;
    localparam logic [31:0] LOCAL_BASE = 32'h4000_0000;
    localparam logic [31:0] BOOT_BASE = 32'h8000_0000;
    localparam logic [31:0] SYS_BASE = 32'hc000_0000;

    // fixed handler addresses used while secure
    localparam logic [31:0] VEC_SCALL = 32'h8000_0004;
    localparam logic [31:0] VEC_EXC = 32'h8000_0008;
    localparam logic [31:0] VEC_NMI = 32'h8000_000c;
    localparam logic [31:0] VEC_BRK = 32'h8000_0010;
    localparam logic [31:0] VEC_INT = 32'h8000_0014;

    // reset values
    localparam logic [31:0] SIZE_RST = 32'h0000_0000;
    localparam logic [3:0] LVL_MASK_RST = 4'h0;

    typedef enum logic [3:0] {
        SEC_RAM = 4'h1,
        SEC_LOCAL = 4'h2,
        SEC_BOOT = 4'h4,
        SEC_SYS = 4'h8
    } section_e;

    typedef enum logic [1:0] {
        ST_BOOT = 2'h1,
        ST_RUN = 2'h2
    } boot_e;

    // status register image
    typedef struct packed {
        logic secure;
        logic gm;
        logic [3:0] lvl_mask;
    } status_s;

    // answer to one access request
    typedef struct packed {
        logic done;
        logic bus_error;
        logic secure_hit;
        section_e section;
    } resp_s;

    // event redirection
    typedef struct packed {
        logic take;
        logic [31:0] vector;
    } event_s;

endpackage : ssac_pkg

/* src/secure_state_access_control.sv */
// secure state checker, memory section decoder and secure event redirection
//
// How it works
// - status_reg.secure always shows whether the core runs secure.
// - secure state reaches all regions; nonsecure state reaches nonsecure regions only.
// - ram and flash secure regions start at memory base, extend by size.
// - ram or flash addresses outside the secure regions are nonsecure.
// - state changes only on the secure call or secure return instruction; boot also sets the flag and chip erase clears it.
// - nonsecure access to secure memory is aborted with a bus error.
// - with the enable fuse set, debugger and nonsecure code cannot reach secure memory; the debugger can while secure with the debug fuse set.
// - enable fuse clears only by chip erase, which also wipes secure regions.
// - boot loads size registers and secure flag before code runs or debug.
// - secure code is debuggable only when the debug fuse is programmed.
// - secure call sets global mask; when secure it masks interrupts and nmi.
// - in secure state each interrupt level is also gated by its level mask.
// - secure call, exceptions and nmi vector to three fixed boot addresses.
// - breakpoint has a fixed vector; all four interrupt levels share one.
// - every exception cause uses the same single secure handler address.
// - secure hardware is off by default; core then behaves as before.
// - four sections: ram from zero, local from its fixed base.
// - boot section starts at the reset fetch address, flash mapped from it.
// - local section serves load-store only, never instruction fetch.
// - local loads and stores complete in one clock cycle.
// - selected access types, such as boot flash writes, may be refused.
module secure_state_access_control #(
    parameter bit BOOT_WRITE_ALLOW = 1'b0
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    // boot preload from the secure flash location and fuses
    input wire logic boot_valid,
    input wire logic [31:0] boot_ram_size,
    input wire logic [31:0] boot_flash_size,
    input wire logic secure_enable_fuse,
    input wire logic secure_debug_fuse,
    input wire logic chip_erase,
    // instruction control
    input wire logic secure_call_instr,
    input wire logic secure_return_instr,
    input wire logic status_write,
    input wire ssac_pkg::status_s status_wdata,
    // fetch, load-store and debugger requests
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_addr,
    input wire logic ls_valid,
    input wire logic ls_write,
    input wire logic [31:0] ls_addr,
    input wire logic dbg_valid,
    input wire logic [31:0] dbg_addr,
    // event sources
    input wire logic [3:0] priority_interrupts,
    input wire logic nonmaskable_interrupt,
    input wire logic exception_req,
    input wire logic breakpoint_req,
    input wire logic [31:0] normal_vector,
    // results
    output ssac_pkg::status_s status_reg,
    output ssac_pkg::resp_s fetch_resp,
    output ssac_pkg::resp_s ls_resp,
    output ssac_pkg::resp_s dbg_resp,
    output ssac_pkg::event_s event_out,
    output logic core_run,
    output logic debug_enable,
    output logic secure_erase,
    output logic [31:0] ram_secure_size,
    output logic [31:0] flash_secure_size
);

    typedef struct packed {
        // boot sequencer and status image
        ssac_pkg::boot_e fsm;
        ssac_pkg::status_s sr;
        // fuse images, latched once at boot so later pin changes have no effect
        logic fuse;
        logic dbg_fuse;
        // secure region sizes in bytes from each memory's base
        logic [31:0] ram_size;
        logic [31:0] flash_size;
        // registered answers, one per requesting unit
        ssac_pkg::resp_s f_resp;
        ssac_pkg::resp_s l_resp;
        ssac_pkg::resp_s d_resp;
        // pending event and the erase pulse
        ssac_pkg::event_s evt;
        logic erase;
    } state_s;

    state_s state_r;
    state_s state_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // helper functions

    // section decode on the top address bits
    // every address falls in exactly one section; the compares overlap, so the first match wins
    function automatic ssac_pkg::section_e decode(input logic [31:0] addr);
        ssac_pkg::section_e sec;
        if (addr >= ssac_pkg::SYS_BASE)
            sec = ssac_pkg::SEC_SYS;
        else if (addr >= ssac_pkg::BOOT_BASE)
            sec = ssac_pkg::SEC_BOOT;
        else if (addr >= ssac_pkg::LOCAL_BASE)
            sec = ssac_pkg::SEC_LOCAL;
        else
            sec = ssac_pkg::SEC_RAM;
        return sec;
    endfunction : decode

    // secure region hit; a region never runs past its own section
    function automatic logic secure_hit(input logic [31:0] addr, input logic [31:0] rsz,
                                        input logic [31:0] fsz);
        logic [31:0] off;
        logic hit;
        // local and system bus addresses are never secure
        hit = 1'b0;
        // offsets count from each memory's own base, so a size of zero protects nothing
        off = addr - ssac_pkg::BOOT_BASE;
        if (decode(addr) == ssac_pkg::SEC_RAM)
            hit = (addr - ssac_pkg::RAM_BASE) < rsz;
        else if (decode(addr) == ssac_pkg::SEC_BOOT)
            hit = off < fsz;
        return hit;
    endfunction : secure_hit

    // one access answer; kind: 0 fetch, 1 load-store, 2 debugger
    // the answer is pure decode of last cycle's state, one cycle after the request
    function automatic ssac_pkg::resp_s check(input logic valid, input logic [1:0] kind,
                                             input logic wr, input logic [31:0] addr,
                                             input state_s s);
        ssac_pkg::resp_s r;
        logic prot;
        logic fetch_local;
        logic boot_write;
        r.done = valid;
        r.section = decode(addr);
        // with the fuse clear no region is protected, matching the older core
        r.secure_hit = s.fuse && secure_hit(addr, s.ram_size, s.flash_size);
        prot = r.secure_hit;
        // the debugger reaches secure memory only while secure code runs with the debug fuse
        if (kind == 2'd2)
            prot = prot && !(s.dbg_fuse && s.sr.secure);
        else
            prot = prot && !s.sr.secure;
        // the local section has no fetch path, so a fetch there can only fail
        fetch_local = (kind == 2'd0) && (r.section == ssac_pkg::SEC_LOCAL);
        // a store into program flash would corrupt code, so it is refused by default
        boot_write = wr && !BOOT_WRITE_ALLOW && (r.section == ssac_pkg::SEC_BOOT);
        // an aborted access still answers in the same cycle as a good one
        r.bus_error = valid && (prot || fetch_local || boot_write);
        return r;
    endfunction : check

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        logic [3:0] int_open;
        logic nmi_open;
        state_nxt = state_r;
        int_open = 4'h0;
        nmi_open = 1'b0;
        // pulses and answers last one cycle; everything else holds
        state_nxt.erase = 1'b0;
        state_nxt.evt.take = 1'b0;
        state_nxt.f_resp = '0;
        state_nxt.l_resp = '0;
        state_nxt.d_resp = '0;
        state_nxt.f_resp.section = ssac_pkg::SEC_RAM;
        state_nxt.l_resp.section = ssac_pkg::SEC_RAM;
        state_nxt.d_resp.section = ssac_pkg::SEC_RAM;
        unique case (state_r.fsm)
            ssac_pkg::ST_BOOT:
            begin
                // requests, instructions and events are ignored until the preload is in
                // preload before the core or the debugger is released
                if (boot_valid)
                begin
                    state_nxt.ram_size = boot_ram_size;
                    state_nxt.flash_size = boot_flash_size;
                    // a set enable fuse starts the core in the secure state
                    state_nxt.fuse = secure_enable_fuse;
                    state_nxt.dbg_fuse = secure_debug_fuse;
                    state_nxt.sr.secure = secure_enable_fuse;
                    state_nxt.fsm = ssac_pkg::ST_RUN;
                end
            end
            ssac_pkg::ST_RUN:
            begin
                // all three units are judged against last cycle's flag and sizes
                // accesses answered the next cycle; local ones never stall
                state_nxt.f_resp = check(fetch_valid, 2'd0, 1'b0, fetch_addr, state_r);
                state_nxt.l_resp = check(ls_valid, 2'd1, ls_write, ls_addr, state_r);
                state_nxt.d_resp = check(dbg_valid, 2'd2, 1'b0, dbg_addr, state_r);
                if (status_write)
                begin
                    // software may change masks but never the secure flag
                    state_nxt.sr.gm = status_wdata.gm;
                    state_nxt.sr.lvl_mask = status_wdata.lvl_mask;
                end
                // placed after the status write, so a call in the same cycle keeps the mask set
                // in run, state moves only on the two dedicated instructions and on chip erase
                if (secure_call_instr && state_r.fuse)
                begin
                    state_nxt.sr.secure = 1'b1;
                    state_nxt.sr.gm = 1'b1;
                end
                else if (secure_return_instr)
                    state_nxt.sr.secure = 1'b0;
                // gm masks the interrupt levels in both states; only nmi looks at the flag
                // event gating; outside secure state nmi is never masked
                int_open = priority_interrupts & ~state_r.sr.lvl_mask;
                if (state_r.sr.gm)
                    int_open = 4'h0;
                nmi_open = nonmaskable_interrupt && !(state_r.sr.secure && state_r.sr.gm);
                if (state_r.sr.secure)
                begin
                    // a call outranks every other source so its entry handler always runs
                    // fixed handlers; the cause of an exception is not passed on
                    state_nxt.evt.take = 1'b1;
                    if (secure_call_instr)
                        state_nxt.evt.vector = ssac_pkg::VEC_SCALL;
                    else if (exception_req)
                        state_nxt.evt.vector = ssac_pkg::VEC_EXC;
                    else if (nmi_open)
                        state_nxt.evt.vector = ssac_pkg::VEC_NMI;
                    else if (breakpoint_req)
                        state_nxt.evt.vector = ssac_pkg::VEC_BRK;
                    else if (|int_open)
                        state_nxt.evt.vector = ssac_pkg::VEC_INT;
                    else
                        state_nxt.evt.take = 1'b0;
                end
                // entering from the nonsecure side still vectors to the call handler
                else if (secure_call_instr && state_r.fuse)
                begin
                    state_nxt.evt.take = 1'b1;
                    state_nxt.evt.vector = ssac_pkg::VEC_SCALL;
                end
                else if (exception_req || nmi_open || breakpoint_req || (|int_open))
                begin
                    // nonsecure events keep the normal vectoring
                    state_nxt.evt.take = 1'b1;
                    state_nxt.evt.vector = normal_vector;
                end
            end
            // an illegal code falls back to boot, where nothing is released
            default:
                state_nxt.fsm = ssac_pkg::ST_BOOT;
        endcase
        // a full chip erase is the only way to clear the enable fuse
        // it also drops the secure flag, so the core never runs secure without the fuse
        if (chip_erase)
        begin
            state_nxt.fuse = 1'b0;
            state_nxt.sr.secure = 1'b0;
            // the pulse asks the memories to wipe every secure region
            state_nxt.erase = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // constants only; the boot state keeps core and debugger parked
            state_r <= '0;
            state_r.fsm <= ssac_pkg::ST_BOOT;
            state_r.sr.secure <= 1'b0;
            state_r.sr.lvl_mask <= ssac_pkg::LVL_MASK_RST;
            state_r.ram_size <= ssac_pkg::SIZE_RST;
            state_r.flash_size <= ssac_pkg::SIZE_RST;
            state_r.f_resp.section <= ssac_pkg::SEC_RAM;
            state_r.l_resp.section <= ssac_pkg::SEC_RAM;
            state_r.d_resp.section <= ssac_pkg::SEC_RAM;
        end
        else
            state_r <= state_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from the state register

    // every output is a flop or a gate on flops, so no address decode reaches a pin
    assign status_reg = state_r.sr;
    assign fetch_resp = state_r.f_resp;
    assign ls_resp = state_r.l_resp;
    assign dbg_resp = state_r.d_resp;
    // the event stands one cycle; the vector holds after it
    assign event_out = state_r.evt;
    // core_run doubles as the release of fetch and debug after the preload
    assign core_run = state_r.fsm == ssac_pkg::ST_RUN;
    // debug stays off during boot and, without the debug fuse, while secure
    assign debug_enable = core_run && !(state_r.sr.secure && !state_r.dbg_fuse);
    assign secure_erase = state_r.erase;
    // sizes are shown as loaded; nothing can rewrite them after boot
    assign ram_secure_size = state_r.ram_size;
    assign flash_secure_size = state_r.flash_size;

endmodule : secure_state_access_control

/* bench/ssac_properties.sv */
// port-level checks of the secure access controller
module ssac_properties
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic boot_valid,
    input wire logic [31:0] boot_ram_size,
    input wire logic secure_enable_fuse,
    input wire logic secure_debug_fuse,
    input wire logic chip_erase,
    input wire logic secure_call_instr,
    input wire logic secure_return_instr,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_addr,
    input wire logic ls_valid,
    input wire logic [31:0] ls_addr,
    input wire ssac_pkg::status_s status_reg,
    input wire ssac_pkg::resp_s fetch_resp,
    input wire ssac_pkg::resp_s ls_resp,
    input wire ssac_pkg::event_s event_out,
    input wire logic core_run,
    input wire logic debug_enable,
    input wire logic secure_erase,
    input wire logic [31:0] ram_secure_size
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////
    // entry to secure state: flag, mask and handler land together
    sequence s_call;
        secure_call_instr && core_run && secure_enable_fuse && !chip_erase;
    endsequence
    sequence s_enter;
        status_reg.secure && status_reg.gm && event_out.take && event_out.vector == ssac_pkg::VEC_SCALL;
    endsequence
    AST_CALL: assert property (s_call |=> s_enter)
        else $error("secure call did not enter secure state");
    AST_LS_DONE: assert property (ls_valid && core_run |=> ls_resp.done)
        else $error("load-store answer late");
    AST_LS_SECTION: assert property (ls_valid && core_run |=> ls_resp.section == 4'h1 << ($past(ls_addr) >> 30))
        else $error("wrong section decode");
    AST_FETCH_LOCAL: assert property (fetch_valid && core_run && fetch_addr[31:30] == 2'h1 |=> fetch_resp.bus_error)
        else $error("fetch from local section not refused");
    AST_NS_ABORT: assert property (ls_resp.done && ls_resp.secure_hit && !$past(status_reg.secure) |-> ls_resp.bus_error)
        else $error("nonsecure access to secure memory not aborted");
    // ram region hit is purely a size compare from address zero
    AST_RAM_REGION: assert property (ls_valid && core_run && ls_addr[31:30] == 2'h0 && secure_enable_fuse
        |=> ls_resp.secure_hit == ($past(ls_addr) < ram_secure_size))
        else $error("ram secure region misjudged");
    AST_STATE_HOLD: assert property (!secure_call_instr && !secure_return_instr && !chip_erase && !boot_valid
        |=> $stable(status_reg.secure))
        else $error("secure flag changed without cause");
    AST_BOOT: assert property (boot_valid && !core_run |=> core_run && status_reg.secure == $past(secure_enable_fuse)
        && ram_secure_size == $past(boot_ram_size))
        else $error("boot preload wrong");
    AST_ERASE: assert property (chip_erase && core_run |=> secure_erase && !status_reg.secure)
        else $error("chip erase did not wipe");
    AST_DEBUG_OFF: assert property (!core_run || (status_reg.secure && $past(status_reg.secure) && !secure_debug_fuse)
        |-> !debug_enable)
        else $error("debug enabled while forbidden");
endmodule : ssac_properties

/* bench/pipe_unit_model.sv */
// fetch, load-store and debug requester issuing one access at a time
module pipe_unit_model
(
    input wire logic clk_sys,
    input wire ssac_pkg::resp_s fetch_resp,
    input wire ssac_pkg::resp_s ls_resp,
    input wire ssac_pkg::resp_s dbg_resp,
    output logic [2:0] req_v,
    output logic req_w,
    output logic [31:0] req_a
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        req_v = 3'h0;
        req_w = 1'b0;
        req_a = 32'h0;
    end
    // raise at a falling edge, taken at the next rising edge; released valid drops, write and address show the inverse
    task automatic req(input logic [3:0] k, input logic w, input logic [31:0] a, output ssac_pkg::resp_s r);
        @(negedge clk_sys);
        req_v = 3'h1 << k;
        req_w = w;
        req_a = a;
        @(negedge clk_sys);
        req_v = 3'h0;
        req_w = ~w;
        req_a = ~a;
        r = (k == 4'h0) ? fetch_resp : (k == 4'h1) ? ls_resp : dbg_resp;
    endtask : req
endmodule : pipe_unit_model

/* bench/testbench.sv */
// bench top: clock, reset, scenarios and verdict
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, arst_n, boot_valid, secure_enable_fuse, secure_debug_fuse, chip_erase, req_w;
    logic secure_call_instr, secure_return_instr, status_write, nonmaskable_interrupt, exception_req, breakpoint_req;
    logic [31:0] boot_ram_size, boot_flash_size, normal_vector, req_a, ram_secure_size, flash_secure_size;
    logic [3:0] priority_interrupts;
    logic [2:0] req_v;
    logic core_run, debug_enable, secure_erase;
    ssac_pkg::status_s status_reg, status_wdata;
    ssac_pkg::resp_s fetch_resp, ls_resp, dbg_resp, r;
    ssac_pkg::event_s event_out;
    int fails = 0;
    int samples_checked = 0;
    secure_state_access_control u_dut (.clk_sys, .arst_n, .boot_valid, .boot_ram_size, .boot_flash_size,
        .secure_enable_fuse, .secure_debug_fuse, .chip_erase, .secure_call_instr, .secure_return_instr,
        .status_write, .status_wdata, .fetch_valid(req_v[0]), .fetch_addr(req_a), .ls_valid(req_v[1]),
        .ls_write(req_w), .ls_addr(req_a), .dbg_valid(req_v[2]), .dbg_addr(req_a), .priority_interrupts,
        .nonmaskable_interrupt, .exception_req, .breakpoint_req, .normal_vector, .status_reg, .fetch_resp,
        .ls_resp, .dbg_resp, .event_out, .core_run, .debug_enable, .secure_erase, .ram_secure_size, .flash_secure_size);
    pipe_unit_model u_cpu (.clk_sys, .fetch_resp, .ls_resp, .dbg_resp, .req_v, .req_w, .req_a);
    ////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask : pulse
    // src bits: ints[3:0], breakpoint, exception, nmi, secure call
    task automatic ev(input logic [7:0] src, input logic t, input logic [31:0] v);
        @(negedge clk_sys);
        {priority_interrupts, breakpoint_req, exception_req, nonmaskable_interrupt, secure_call_instr} = src;
        @(negedge clk_sys);
        {priority_interrupts, breakpoint_req, exception_req, nonmaskable_interrupt, secure_call_instr} = 8'h0;
        check(event_out.take, t);
        if (t)
            check(event_out.vector, v);
    endtask : ev
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////
    // boot with the enable fuse set, then leave secure state
    task automatic t_boot();
        secure_enable_fuse = 1'b1;
        pulse(boot_valid);
        check({core_run, status_reg.secure, debug_enable}, 3'h6);
        check(ram_secure_size, 32'h0000_0100);
        check(flash_secure_size, 32'h0000_0800);
        u_cpu.req(4'h1, 1'b0, 32'h0000_0010, r);
        check({r.bus_error, r.secure_hit}, 2'h1);
        u_cpu.req(4'h2, 1'b0, 32'h0000_0010, r);
        check(r.bus_error, 1'b1);
        pulse(secure_return_instr);
        check({status_reg.secure, debug_enable}, 2'h1);
        status_wdata = 6'h20;
        pulse(status_write);
        check(status_reg.secure, 1'b0);
    endtask : t_boot
    // nonsecure accesses; te digits: unit, write, error, hit, section
    task automatic t_access();
        logic [31:0] ta [10] = '{32'h0000_0010, 32'h0000_0100, 32'h8000_07ff, 32'h8000_0800, 32'h8000_0800,
            32'h4000_0000, 32'h4000_0000, 32'h0000_00ff, 32'hc000_0000, 32'h0000_0010};
        logic [19:0] te [10] = '{20'h10111, 20'h10001, 20'h10114, 20'h10004, 20'h11104,
            20'h11002, 20'h00102, 20'h00111, 20'h00008, 20'h20111};
        for (int i = 0; i < 10; i++)
        begin
            u_cpu.req(te[i][19:16], te[i][12], ta[i], r);
            check({r.done, r.bus_error, r.secure_hit, r.section}, {1'b1, te[i][8], te[i][4], te[i][3:0]});
        end
    endtask : t_access
    // redirection and masking of events around a secure call
    task automatic t_events();
        ev(8'h02, 1'b1, 32'h1234_5678);
        ev(8'h01, 1'b1, ssac_pkg::VEC_SCALL);
        check({status_reg.secure, status_reg.gm}, 2'h3);
        ev(8'h02, 1'b0, 32'h0);
        ev(8'h10, 1'b0, 32'h0);
        ev(8'h04, 1'b1, ssac_pkg::VEC_EXC);
        ev(8'h08, 1'b1, ssac_pkg::VEC_BRK);
        status_wdata = 6'h0f;
        pulse(status_write);
        ev(8'h40, 1'b0, 32'h0);
        ev(8'h02, 1'b1, ssac_pkg::VEC_NMI);
        status_wdata = 6'h00;
        pulse(status_write);
        ev(8'h80, 1'b1, ssac_pkg::VEC_INT);
        ev(8'h10, 1'b1, ssac_pkg::VEC_INT);
    endtask : t_events
    // erase clears the fuse image, so secure calls no longer take effect
    task automatic t_erase();
        secure_enable_fuse = 1'b0;
        pulse(chip_erase);
        check({secure_erase, status_reg.secure}, 2'h2);
        u_cpu.req(4'h1, 1'b0, 32'h0000_0010, r);
        check({r.bus_error, r.secure_hit}, 2'h0);
        ev(8'h01, 1'b0, 32'h0);
        check(status_reg.secure, 1'b0);
    endtask : t_erase
    // second reset in mid-run, boot with both fuses: secure code may be debugged
    task automatic t_debug();
        @(negedge clk_sys);
        arst_n = 1'b0;
        {secure_enable_fuse, secure_debug_fuse} = 2'h3;
        @(negedge clk_sys);
        check({core_run, status_reg.secure, debug_enable, secure_erase}, 4'h0);
        arst_n = 1'b1;
        pulse(boot_valid);
        check({core_run, status_reg.secure, debug_enable}, 3'h7);
        u_cpu.req(4'h2, 1'b0, 32'h8000_0010, r);
        check({r.bus_error, r.secure_hit, r.section}, 6'h14);
        u_cpu.req(4'h1, 1'b0, 32'h0000_0010, r);
        check({r.bus_error, r.secure_hit}, 2'h1);
    endtask : t_debug
    ////////////////////////////////////////
    initial
    begin
        {arst_n, boot_valid, secure_enable_fuse, secure_debug_fuse, chip_erase, secure_call_instr} = 6'h0;
        {secure_return_instr, status_write, nonmaskable_interrupt, exception_req, breakpoint_req} = 5'h0;
        {boot_ram_size, boot_flash_size, normal_vector} = {32'h0000_0100, 32'h0000_0800, 32'h1234_5678};
        priority_interrupts = 4'h0;
        status_wdata = 6'h00;
        repeat (16) @(negedge clk_sys);
        check({status_reg, ls_resp, core_run, event_out.take}, 15'h0004);
        arst_n = 1'b1;
        t_boot();
        t_access();
        t_events();
        t_erase();
        t_debug();
        end_of_test();
    end
    // a hung handshake ends the run as a failure
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        fails++;
        end_of_test();
    end
endmodule : testbench
bind secure_state_access_control ssac_properties u_props (.clk_sys, .arst_n, .boot_valid, .boot_ram_size,
    .secure_enable_fuse, .secure_debug_fuse, .chip_erase, .secure_call_instr, .secure_return_instr, .fetch_valid,
    .fetch_addr, .ls_valid, .ls_addr, .status_reg, .fetch_resp, .ls_resp, .event_out, .core_run, .debug_enable,
    .secure_erase, .ram_secure_size);
